// [design/accel_regs_pkg.sv]
// Register map, field layout and reset constants for the accelerometer event register slice
`default_nettype none
package accel_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 16;
	localparam logic [7:0] ACCEL_Y_LOW_OFS = 8'h2a;
	localparam logic [7:0] ACCEL_Y_HIGH_OFS = 8'h2b;
	localparam logic [7:0] ACCEL_Z_LOW_OFS = 8'h2c;
	localparam logic [7:0] ACCEL_Z_HIGH_OFS = 8'h2d;
	localparam logic [7:0] BUFFER_CONTROL_OFS = 8'h2e;
	localparam logic [7:0] BUFFER_STATUS_OFS = 8'h2f;
	localparam logic [7:0] EVENT1_CONFIG_OFS = 8'h30;
	localparam logic [7:0] EVENT1_SOURCE_OFS = 8'h31;
	localparam logic [7:0] EVENT1_THRESHOLD_OFS = 8'h32;
	localparam logic [7:0] BUFFER_CONTROL_RST = 8'h00;
	localparam logic [7:0] EVENT1_CONFIG_RST = 8'h00;
	localparam logic [7:0] EVENT1_SOURCE_RST = 8'h00;
	localparam logic [6:0] EVENT1_THRESHOLD_RST = 7'h00;
	// Field positions
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int PIN_CHOICE_BIT = 5;
	localparam int LEVEL_LIMIT_HI = 4;
	localparam int COMBINE_BIT = 7;
	localparam int SIX_DIR_BIT = 6;
	localparam int ACTIVE_BIT = 6;
	localparam int THS_HI = 6;
	// Buffer mode codes
	localparam logic [1:0] MODE_BYPASS = 2'h0;
	localparam logic [1:0] MODE_FIFO = 2'h1;
	localparam logic [1:0] MODE_STREAM = 2'h2;
	localparam logic [1:0] MODE_TRIGGER = 2'h3;
	// Event modes, {combine, six-direction}
	localparam logic [1:0] EV_OR = 2'h0;
	localparam logic [1:0] EV_MOVE = 2'h1;
	localparam logic [1:0] EV_AND = 2'h2;
	localparam logic [1:0] EV_POSITION = 2'h3;
	// Cycles of the boot load before writes to the event configuration are accepted
	localparam int BOOT_CYCLES = 16;
	typedef enum logic [1:0] {BOOTING, RUNNING} boot_state_e;
endpackage
`default_nettype wire

// [design/axis_compare.sv]
// Per-axis high and low threshold comparison for one signed sample
`default_nettype none
module axis_compare (
	input wire logic signed [15:0] sample,
	input wire logic [6:0] threshold,
	output logic high_event,
	output logic low_event
);
	logic signed [15:0] ths_scaled;
	// Threshold occupies the upper magnitude bits of the sample
	assign ths_scaled = $signed({1'b0, threshold, 8'h00});
	// Above threshold is high, below minus threshold is low
	assign high_event = sample > ths_scaled;
	assign low_event = sample < -ths_scaled;
endmodule
`default_nettype wire

// [design/accel_event_regs.sv]
// Accelerometer output, buffer control and first inertial event register slice
// Notes on behaviour
// - Y sample as two's complement byte pair
// - Z sample as two's complement byte pair
// - Buffer mode resets bypass; four codes
// - Trigger pin choice resets zero
// - Mode top, trigger, five-bit limit low
// - Status: watermark, overrun, empty, level count
// - Combine and six-direction bits select mode
// - Movement mode pulses one sample period
// - Position mode holds while in zone
// - Six axis enables reset to zero
// - Config loaded at boot; writes after boot
// - Source: zero, active, Z Y X flags
// - Axis flag set when its event occurred
// - Source register ignores writes
// - Source read clears active and pin
// - Seven-bit threshold resets to zero
// - Latch holds request until source read
// - Four-direction option drops Z directions in six-direction modes
// - Byte order option swaps low address byte
// - Hold option freezes outputs until both read
`default_nettype none
module accel_event_regs (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [accel_regs_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [accel_regs_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [accel_regs_pkg::DATA_W-1:0] reg_rdata,
	input wire logic signed [accel_regs_pkg::SAMPLE_W-1:0] accel_x_in,
	input wire logic signed [accel_regs_pkg::SAMPLE_W-1:0] accel_y_in,
	input wire logic signed [accel_regs_pkg::SAMPLE_W-1:0] accel_z_in,
	input wire logic sample_strobe,
	input wire logic byte_order_sel,
	input wire logic hold_output_update,
	input wire logic latch_request_one,
	input wire logic four_direction_one,
	input wire logic watermark_flag,
	input wire logic buffer_overrun_flag,
	input wire logic buffer_empty_flag,
	input wire logic [4:0] stored_sample_count,
	output logic [1:0] buffer_mode_sel,
	output logic event_pin_choice,
	output logic [4:0] buffer_level_limit,
	output logic irq_line_one,
	output logic boot_done
);
	import accel_regs_pkg::*;

	logic [15:0] y_q, z_q;
	logic y_lo_read_q, y_hi_read_q, z_lo_read_q, z_hi_read_q;
	logic [7:0] fifo_ctrl_q;
	logic [7:0] cfg_q;
	logic [6:0] ths_q;
	logic [5:0] flags_q;
	logic active_q;
	logic pulse_q;
	logic in_zone_q;
	logic [4:0] boot_cnt_q;
	boot_state_e boot_q;
	logic [5:0] raw_ev, en_ev, hit_ev;
	logic any_en, combo, in_zone, zone_entry, event_now;
	logic src_read;
	logic [1:0] ev_mode;
	logic [7:0] rdata_d;
	logic signed [SAMPLE_W-1:0] axis_in [3];
	wire logic [2:0] axis_high;
	wire logic [2:0] axis_low;
	logic y_reload, z_reload;

	// Samples in axis order X, Y, Z for the comparators
	assign axis_in = '{accel_x_in, accel_y_in, accel_z_in};

	// Threshold comparison per axis
	for (genvar g = 0; g < 3; g++) begin : g_axis
		axis_compare axis_compare_inst (
			.sample(axis_in[g]),
			.threshold(ths_q),
			.high_event(axis_high[g]),
			.low_event(axis_low[g])
		);
	end

	// Byte order per address: low byte at lower address unless swapped
	function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic upper_addr, input logic swap);
		pick_byte = (upper_addr ^ swap) ? v[15:8] : v[7:0];
	endfunction

	assign src_read = reg_read && (reg_addr == EVENT1_SOURCE_OFS);
	assign ev_mode = {cfg_q[COMBINE_BIT], cfg_q[SIX_DIR_BIT]};

	// A new sample loads unless an unread byte pair holds it
	assign y_reload = sample_strobe && (!hold_output_update || (y_lo_read_q && y_hi_read_q));
	assign z_reload = sample_strobe && (!hold_output_update || (z_lo_read_q && z_hi_read_q));

	// Event vector ordered Z high, Z low, Y high, Y low, X high, X low
	always_comb begin
		raw_ev = {axis_high[2], axis_low[2], axis_high[1], axis_low[1], axis_high[0], axis_low[0]};
		en_ev = cfg_q[5:0];
		// Four-direction detection drops the Z directions
		if (four_direction_one && cfg_q[SIX_DIR_BIT]) begin
			en_ev[5:4] = 2'b00;
		end
		hit_ev = raw_ev & en_ev;
		any_en = |en_ev;
		// AND needs every enabled event, OR needs any
		if (cfg_q[COMBINE_BIT]) begin
			combo = any_en && ((raw_ev & en_ev) == en_ev);
		end else begin
			combo = |hit_ev;
		end
		// Known zone: an enabled direction is reached
		in_zone = |hit_ev;
		zone_entry = in_zone && !in_zone_q;
		case (ev_mode)
			EV_MOVE: event_now = pulse_q;
			EV_POSITION: event_now = in_zone;
			default: event_now = combo;
		endcase
	end

	// Boot load length counter, frozen once the load is over
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			boot_cnt_q <= 5'h00;
		end else if (boot_q == BOOTING) begin
			boot_cnt_q <= boot_cnt_q + 5'h01;
		end
	end

	// Boot load sequence; config writes refused until it ends
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			boot_q <= BOOTING;
		end else begin
			case (boot_q)
				BOOTING: begin
					if (boot_cnt_q == 5'(BOOT_CYCLES - 1)) begin
						boot_q <= RUNNING;
					end
				end
				default: boot_q <= RUNNING;
			endcase
		end
	end

	// Boot done flag, one edge after the load ends
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			boot_done <= 1'b0;
		end else begin
			boot_done <= (boot_q == RUNNING);
		end
	end

	// Buffer control register, writable from the first edge
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fifo_ctrl_q <= BUFFER_CONTROL_RST;
		end else if (reg_write && reg_addr == BUFFER_CONTROL_OFS) begin
			fifo_ctrl_q <= reg_wdata;
		end
	end

	// Event configuration; a write during the boot load is dropped
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= EVENT1_CONFIG_RST;
		end else if (reg_write && reg_addr == EVENT1_CONFIG_OFS && boot_q == RUNNING) begin
			cfg_q <= reg_wdata;
		end
	end

	// Event threshold; the reserved top bit is not stored
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ths_q <= EVENT1_THRESHOLD_RST;
		end else if (reg_write && reg_addr == EVENT1_THRESHOLD_OFS) begin
			ths_q <= reg_wdata[THS_HI:0];
		end
	end

	// Buffer mode field driven out
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			buffer_mode_sel <= MODE_BYPASS;
		end else begin
			buffer_mode_sel <= fifo_ctrl_q[MODE_HI:MODE_LO];
		end
	end

	// Trigger pin choice driven out
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			event_pin_choice <= 1'b0;
		end else begin
			event_pin_choice <= fifo_ctrl_q[PIN_CHOICE_BIT];
		end
	end

	// Buffer level limit driven out
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			buffer_level_limit <= 5'h00;
		end else begin
			buffer_level_limit <= fifo_ctrl_q[LEVEL_LIMIT_HI:0];
		end
	end

	// Y byte reads since the last load, for block data update
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			y_lo_read_q <= 1'b0;
			y_hi_read_q <= 1'b0;
		end else if (y_reload) begin
			y_lo_read_q <= 1'b0;
			y_hi_read_q <= 1'b0;
		end else if (reg_read && reg_addr == ACCEL_Y_LOW_OFS) begin
			y_lo_read_q <= 1'b1;
		end else if (reg_read && reg_addr == ACCEL_Y_HIGH_OFS) begin
			y_hi_read_q <= 1'b1;
		end
	end

	// Z byte reads since the last load, for block data update
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			z_lo_read_q <= 1'b0;
			z_hi_read_q <= 1'b0;
		end else if (z_reload) begin
			z_lo_read_q <= 1'b0;
			z_hi_read_q <= 1'b0;
		end else if (reg_read && reg_addr == ACCEL_Z_LOW_OFS) begin
			z_lo_read_q <= 1'b1;
		end else if (reg_read && reg_addr == ACCEL_Z_HIGH_OFS) begin
			z_hi_read_q <= 1'b1;
		end
	end

	// Y output sample, held until both bytes read when enabled
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			y_q <= 16'h0000;
		end else if (y_reload) begin
			y_q <= accel_y_in;
		end
	end

	// Z output sample, held until both bytes read when enabled
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			z_q <= 16'h0000;
		end else if (z_reload) begin
			z_q <= accel_z_in;
		end
	end

	// Movement pulse: zone entry at a sample, held one sample period
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pulse_q <= 1'b0;
		end else if (sample_strobe) begin
			pulse_q <= zone_entry;
		end
	end

	// Zone state at the last sample, for entry detection
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			in_zone_q <= 1'b0;
		end else if (sample_strobe) begin
			in_zone_q <= in_zone;
		end
	end

	// Source flags: follow hits, or gather them until a read when latched
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= EVENT1_SOURCE_RST[5:0];
		end else if (!latch_request_one) begin
			flags_q <= hit_ev;
		end else if (event_now) begin
			flags_q <= flags_q | hit_ev;
		end else if (src_read) begin
			flags_q <= hit_ev;
		end
	end

	// Active bit; a new event wins over the read clear
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			active_q <= EVENT1_SOURCE_RST[ACTIVE_BIT];
		end else if (event_now) begin
			active_q <= 1'b1;
		end else if (src_read || !latch_request_one) begin
			active_q <= 1'b0;
		end
	end

	// Interrupt pin follows the active bit
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irq_line_one <= 1'b0;
		end else begin
			irq_line_one <= active_q && !src_read;
		end
	end

	// Read data mux; source register has no write path
	always_comb begin
		rdata_d = 8'h00;
		if (reg_addr == ACCEL_Y_LOW_OFS) begin
			rdata_d = pick_byte(y_q, 1'b0, byte_order_sel);
		end else if (reg_addr == ACCEL_Y_HIGH_OFS) begin
			rdata_d = pick_byte(y_q, 1'b1, byte_order_sel);
		end else if (reg_addr == ACCEL_Z_LOW_OFS) begin
			rdata_d = pick_byte(z_q, 1'b0, byte_order_sel);
		end else if (reg_addr == ACCEL_Z_HIGH_OFS) begin
			rdata_d = pick_byte(z_q, 1'b1, byte_order_sel);
		end else if (reg_addr == BUFFER_CONTROL_OFS) begin
			rdata_d = fifo_ctrl_q;
		end else if (reg_addr == BUFFER_STATUS_OFS) begin
			rdata_d = {watermark_flag, buffer_overrun_flag, buffer_empty_flag, stored_sample_count};
		end else if (reg_addr == EVENT1_CONFIG_OFS) begin
			rdata_d = cfg_q;
		end else if (reg_addr == EVENT1_SOURCE_OFS) begin
			rdata_d = {1'b0, active_q, flags_q};
		end else if (reg_addr == EVENT1_THRESHOLD_OFS) begin
			rdata_d = {1'b0, ths_q};
		end
	end

	// Read data registered on a read strobe
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= rdata_d;
		end
	end
endmodule
`default_nettype wire

// [tb/accel_event_regs_props.sv]
// Checker on the register port and outputs of the event register slice
`default_nettype none
module accel_event_regs_props
	import accel_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [accel_regs_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [accel_regs_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [accel_regs_pkg::DATA_W-1:0] reg_rdata,
	input wire logic watermark_flag,
	input wire logic buffer_overrun_flag,
	input wire logic buffer_empty_flag,
	input wire logic [4:0] stored_sample_count,
	input wire logic [1:0] buffer_mode_sel,
	input wire logic event_pin_choice,
	input wire logic [4:0] buffer_level_limit,
	input wire logic boot_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] boot_cnt_q;
	logic [7:0] ctrl_q;
	logic [7:0] cfg_q;
	logic [6:0] ths_q;
	wire logic rd = reg_read && !reg_write;
	wire logic wr_ctrl = reg_write && reg_addr == BUFFER_CONTROL_OFS;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Cycles since reset and the last writes that should have been accepted
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			boot_cnt_q <= 5'h00;
			ctrl_q <= BUFFER_CONTROL_RST;
			cfg_q <= EVENT1_CONFIG_RST;
			ths_q <= EVENT1_THRESHOLD_RST;
		end else begin
			boot_cnt_q <= boot_cnt_q + 5'(boot_cnt_q != 5'h1f);
			if (wr_ctrl) ctrl_q <= reg_wdata;
			if (reg_write && boot_cnt_q >= 5'(BOOT_CYCLES) && reg_addr == EVENT1_CONFIG_OFS) cfg_q <= reg_wdata;
			if (reg_write && reg_addr == EVENT1_THRESHOLD_OFS) ths_q <= reg_wdata[6:0];
		end
	end
	property p_boot_early; boot_done |-> boot_cnt_q > BOOT_CYCLES; endproperty
	a_boot_early: assert property (p_boot_early) else $error("boot ended too early");
	property p_boot_late; boot_cnt_q > BOOT_CYCLES + 1 |-> boot_done; endproperty
	a_boot_late: assert property (p_boot_late) else $error("boot ended too late");
	property p_ctrl_out;
		!$past(wr_ctrl) && !$past(wr_ctrl, 2) |-> {buffer_mode_sel, event_pin_choice, buffer_level_limit} == ctrl_q;
	endproperty
	a_ctrl_out: assert property (p_ctrl_out) else $error("buffer outputs differ");
	property p_rd_ctrl; rd && reg_addr == BUFFER_CONTROL_OFS |=> reg_rdata == ctrl_q; endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("buffer control read wrong");
	property p_rd_status;
		rd && reg_addr == BUFFER_STATUS_OFS |=> reg_rdata ==
			$past({watermark_flag, buffer_overrun_flag, buffer_empty_flag, stored_sample_count});
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("buffer status read wrong");
	property p_rd_cfg; rd && reg_addr == EVENT1_CONFIG_OFS |=> reg_rdata == cfg_q; endproperty
	a_rd_cfg: assert property (p_rd_cfg) else $error("event config read wrong");
	property p_rd_src; rd && reg_addr == EVENT1_SOURCE_OFS |=> !reg_rdata[7]; endproperty
	a_rd_src: assert property (p_rd_src) else $error("source top bit set");
	property p_rd_ths; rd && reg_addr == EVENT1_THRESHOLD_OFS |=> reg_rdata == {1'b0, ths_q}; endproperty
	a_rd_ths: assert property (p_rd_ths) else $error("threshold read wrong");
endmodule
`default_nettype wire

// [tb/host_model.sv]
// Host side of the register port: one-cycle write and read strobes
`default_nettype none
module host_model
	import accel_regs_pkg::*;
(
	input wire logic ref_clk,
	output logic [accel_regs_pkg::ADDR_W-1:0] reg_addr,
	output logic [accel_regs_pkg::DATA_W-1:0] reg_wdata,
	output logic reg_write,
	output logic reg_read
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		{reg_addr, reg_wdata, reg_write, reg_read} = 18'h00000;
	end
	// One strobe, driven after an edge and held until the next edge takes it
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = (a == EVENT1_THRESHOLD_OFS) ? {1'b0, d[6:0]} : d;
		reg_write = w;
		reg_read = !w;
		@(posedge ref_clk);
		#1;
		{reg_write, reg_read} = 2'h0;
		reg_addr = ~a; // Released lines do not keep the last value
		reg_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// [tb/accel_event_regs_tb.sv]
// Self-checking bench: host model drives registers, a monitor checks each read answer
`default_nettype none
module accel_event_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import accel_regs_pkg::*;
	logic ref_clk = 1'b0, rstn = 1'b0, pend = 1'b0, p;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, exp_q[$];
	logic reg_write, reg_read, sample_strobe, byte_order_sel, hold_output_update, latch_request_one;
	logic four_direction_one, watermark_flag, buffer_overrun_flag, buffer_empty_flag, event_pin_choice;
	logic irq_line_one, boot_done;
	logic [4:0] stored_sample_count, buffer_level_limit;
	logic [1:0] buffer_mode_sel;
	logic signed [15:0] accel_x_in, accel_y_in, accel_z_in, s;
	int n_mismatch = 0, n_checks = 0, seed = 56;
	always #20 ref_clk = ~ref_clk;
	accel_event_regs accel_event_regs_inst (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .accel_x_in, .accel_y_in, .accel_z_in, .sample_strobe, .byte_order_sel, .hold_output_update,
		.latch_request_one, .four_direction_one, .watermark_flag, .buffer_overrun_flag, .buffer_empty_flag,
		.stored_sample_count, .buffer_mode_sel, .event_pin_choice, .buffer_level_limit, .irq_line_one, .boot_done);
	host_model host_model_inst (.ref_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read);
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_model_inst.access(a, 8'h00, 1'b0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		host_model_inst.access(a, v, 1'b1);
	endtask
	// One sample period, then the interrupt line is compared
	task automatic irq_is(input logic e);
		tick(1);
		sample_strobe = 1'b1;
		tick(1);
		sample_strobe = 1'b0;
		tick(3);
		check({7'h00, irq_line_one}, {7'h00, e});
	endtask
	// Oldest expectation against the answer one cycle after each read
	always @(posedge ref_clk) begin
		p = reg_read;
		if (pend) begin
			#2;
			check(reg_rdata, exp_q.pop_front());
		end
		pend = p;
	end
	// Watchdog for a hung run
	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		{sample_strobe, byte_order_sel, hold_output_update, latch_request_one, four_direction_one} = 5'h00;
		{watermark_flag, buffer_overrun_flag, buffer_empty_flag, stored_sample_count} = 8'h00;
		{accel_x_in, accel_y_in, accel_z_in} = 48'h0;
		tick(16);
		rstn = 1'b1;
		wr(EVENT1_CONFIG_OFS, 8'h3f);
		rd(BUFFER_CONTROL_OFS, 8'h00);
		rd(EVENT1_CONFIG_OFS, 8'h00);
		rd(EVENT1_SOURCE_OFS, 8'h00);
		rd(EVENT1_THRESHOLD_OFS, 8'h00);
		rd(8'h40, 8'h00);
		for (int i = 0; i < 40 && boot_done !== 1'b1; i++) tick(1);
		check({7'h00, boot_done}, 8'h01);
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			d = {m[1:0], m[0], 5'($random(seed))};
			wr(BUFFER_CONTROL_OFS, d);
			rd(BUFFER_CONTROL_OFS, d);
			check({buffer_mode_sel, event_pin_choice, buffer_level_limit}, d);
			d = 8'($random(seed));
			{watermark_flag, buffer_overrun_flag, buffer_empty_flag, stored_sample_count} = d;
			rd(BUFFER_STATUS_OFS, d);
		end
		wr(EVENT1_SOURCE_OFS, 8'hff);
		rd(EVENT1_SOURCE_OFS, 8'h00);
		$display("test buffer done");
		for (int b = 0; b < 2; b++) begin
			byte_order_sel = b[0];
			accel_y_in = 16'($random(seed));
			accel_z_in = 16'($random(seed));
			irq_is(1'b0);
			rd(ACCEL_Y_LOW_OFS, b ? accel_y_in[15:8] : accel_y_in[7:0]);
			rd(ACCEL_Y_HIGH_OFS, b ? accel_y_in[7:0] : accel_y_in[15:8]);
			rd(ACCEL_Z_LOW_OFS, b ? accel_z_in[15:8] : accel_z_in[7:0]);
			rd(ACCEL_Z_HIGH_OFS, b ? accel_z_in[7:0] : accel_z_in[15:8]);
		end
		{hold_output_update, byte_order_sel} = 2'h2;
		s = 16'($random(seed));
		accel_y_in = s;
		irq_is(1'b0);
		rd(ACCEL_Y_LOW_OFS, s[7:0]);
		accel_y_in = ~s;
		irq_is(1'b0);
		rd(ACCEL_Y_HIGH_OFS, s[15:8]);
		hold_output_update = 1'b0;
		$display("test samples done");
		{accel_x_in, accel_y_in, accel_z_in} = 48'h0;
		wr(EVENT1_THRESHOLD_OFS, 8'h90);
		rd(EVENT1_THRESHOLD_OFS, 8'h10);
		wr(EVENT1_CONFIG_OFS, 8'h08);
		rd(EVENT1_CONFIG_OFS, 8'h08);
		accel_y_in = 16'sh1001;
		irq_is(1'b1);
		rd(EVENT1_SOURCE_OFS, 8'h48);
		accel_y_in = 16'sh1000;
		irq_is(1'b0);
		accel_y_in = -16'sh1001;
		irq_is(1'b0);
		wr(EVENT1_CONFIG_OFS, 8'ha8);
		accel_y_in = 16'sh1001;
		irq_is(1'b0);
		accel_z_in = 16'sh1001;
		irq_is(1'b1);
		accel_z_in = 16'sh0000;
		irq_is(1'b0);
		latch_request_one = 1'b1;
		wr(EVENT1_CONFIG_OFS, 8'h08);
		irq_is(1'b1);
		accel_y_in = 16'sh0000;
		irq_is(1'b1);
		rd(EVENT1_SOURCE_OFS, 8'h48);
		irq_is(1'b0);
		rd(EVENT1_SOURCE_OFS, 8'h00);
		latch_request_one = 1'b0;
		wr(EVENT1_CONFIG_OFS, 8'he0);
		accel_z_in = 16'sh1001;
		irq_is(1'b1);
		irq_is(1'b1);
		four_direction_one = 1'b1;
		irq_is(1'b0);
		{four_direction_one, accel_z_in} = 17'h0;
		irq_is(1'b0);
		wr(EVENT1_CONFIG_OFS, 8'h60);
		accel_z_in = 16'sh1001;
		irq_is(1'b1);
		irq_is(1'b0);
		$display("test events done");
		stop_test();
	end
endmodule
bind accel_event_regs accel_event_regs_props accel_event_regs_props_inst (.ref_clk, .rstn, .reg_addr,
	.reg_wdata, .reg_write, .reg_read, .reg_rdata, .watermark_flag, .buffer_overrun_flag, .buffer_empty_flag,
	.stored_sample_count, .buffer_mode_sel, .event_pin_choice, .buffer_level_limit, .boot_done);
`default_nettype wire
